// ===== hdl/cfs_pkg.sv
package cfs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Frequency glide step period.
    localparam int unsigned GLIDE_TICK_NS = 1000;
    localparam int unsigned GLIDE_TICK_CYC = GLIDE_TICK_NS / CLK_PERIOD_NS;
    // Watchdog unit and reset pulse width.
    localparam int unsigned WD_UNIT_MS = 250;
    localparam int unsigned RST_PULSE_MS = 250;
    localparam int unsigned NS_PER_MS = 1000000;

    // ------------------------------------------------------------
    // Register map, 4-bit word address, 16-bit data
    // ------------------------------------------------------------
    localparam logic [3:0] REG_SEL_CTRL = 4'h0;
    localparam logic [3:0] REG_CLK_EN = 4'h1;
    localparam logic [3:0] REG_WD_TIME = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_CPU_FREQ = 4'h4;
    // Field positions.
    localparam int SEL_SRC_BIT = 5;
    localparam int SEL_WDEN_BIT = 6;
    localparam int ST_TIMEOUT_BIT = 7;
    // Reset values.
    localparam logic [15:0] CLK_EN_RST = 16'hffff;
    localparam logic [7:0] WD_TIME_RST = 8'h08;
    localparam logic [4:0] SW_CODE_RST = 5'h00;

    // ------------------------------------------------------------
    // Frequency table, CPU clock in 10 kHz units
    // ------------------------------------------------------------
    localparam logic [15:0] GLIDE_STEP = 16'h000a;
    localparam logic [4:0] DOWN_CODE_A = 5'h01;
    localparam logic [4:0] DOWN_CODE_B = 5'h11;
    localparam logic [15:0] CPU_FREQ_TAB [32] = '{
        16'h276a, 16'h272e, 16'h283c, 16'h2904, 16'h29cc, 16'h2a94, 16'h2b5c, 16'h2c88,
        16'h2db4, 16'h2ee0, 16'h319c, 16'h32c8, 16'h3415, 16'h4268, 16'h4650, 16'h4a38,
        16'h344e, 16'h3415, 16'h2ee0, 16'h30d4, 16'h34b2, 16'h3584, 16'h364c, 16'h3714,
        16'h37dc, 16'h38a4, 16'h3a98, 16'h3c8c, 16'h3e80, 16'h4268, 16'h1a0b, 16'h4e20
    };

    // Values captured from the shared strap pins.
    typedef struct packed {
        logic [4:0] hw_freq_code;
        logic current_mode_strap;
        logic watchdog_strap_enable;
    } cfs_strap_t;

    typedef enum logic {ST_STRAP, ST_RUN} cfs_state_t;

endpackage : cfs_pkg

// ===== hdl/cfs_freq_glide.sv
`timescale 1ns/1ps
module cfs_freq_glide (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic [15:0] target,
    output logic [15:0] cur,
    output logic busy
);
    import cfs_pkg::*;

    logic [15:0] diff;
    logic up;

    // Distance to the target, never negative.
    assign up = target > cur;
    assign diff = up ? target - cur : cur - target;

    // bounded glide
    // Move one small step per tick so the PLL never sees a jump.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= CPU_FREQ_TAB[0];
        end else if (tick && diff != 16'h0000) begin
            if (diff <= GLIDE_STEP) begin
                cur <= target;
            end else if (up) begin
                cur <= cur + GLIDE_STEP;
            end else begin
                cur <= cur - GLIDE_STEP;
            end
        end
    end

    assign busy = diff != 16'h0000;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_glide_step_size: assert property (
        (cur >= $past(cur) ? cur - $past(cur) : $past(cur) - cur) <= GLIDE_STEP)
        else $error("Frequency moved by more than one glide step.");

endmodule : cfs_freq_glide

// ===== hdl/cfs_top.sv
`timescale 1ns/1ps

module cfs_top #(
    parameter int unsigned WD_UNIT_CYC =
        cfs_pkg::WD_UNIT_MS * (cfs_pkg::NS_PER_MS / cfs_pkg::CLK_PERIOD_NS),
    parameter int unsigned RST_PULSE_CYC =
        cfs_pkg::RST_PULSE_MS * (cfs_pkg::NS_PER_MS / cfs_pkg::CLK_PERIOD_NS)
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic POWER_GOOD_IN,
    input wire logic CURRENT_MODE_STRAP,
    input wire logic [4:0] FS_PIN_I,
    output logic [4:0] FS_PIN_O,
    output logic [4:0] FS_PIN_OE_N,
    input wire logic WD_PIN_I,
    output logic WD_PIN_O,
    output logic WD_PIN_OE_N,
    output logic RST_PIN_O,
    output logic RST_PIN_OE_N,
    output logic POWER_DOWN_N,
    output logic [15:0] CLK_GATE,
    output logic [4:0] FREQ_CODE,
    output logic SPREAD_DOWN,
    output logic [15:0] CPU_FREQ,
    output logic IREF_MULT6,
    output cfs_pkg::cfs_strap_t STRAP
);
    import cfs_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic pg_q;
    logic pg_s;
    logic [4:0] fs_s;

    // Every pin crosses two flops before anything looks at it.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
            pg_q <= 1'b0;
        end else begin
            sync1 <= {CURRENT_MODE_STRAP, WD_PIN_I, POWER_GOOD_IN, FS_PIN_I};
            sync2 <= sync1;
            pg_q <= sync2[5];
        end
    end

    assign fs_s = sync2[4:0];
    assign pg_s = sync2[5];

    // ------------------------------------------------------------
    // Strap capture and pin turnaround
    // ------------------------------------------------------------
    cfs_state_t state;
    logic strap_latched;
    logic pg_rise;

    assign pg_rise = pg_s && !pg_q;
    assign strap_latched = state == ST_RUN;

    // capture once
    // Captured once on the power-good edge; later pin activity is
    // the clock itself and must not reach the code.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            state <= ST_STRAP;
            STRAP <= '0;
        end else begin
            unique case (state)
                ST_STRAP: begin
                    if (pg_rise) begin
                        state <= ST_RUN;
                        STRAP <= '{fs_s, sync2[7], sync2[6]};
                    end
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // pin turnaround
    // Pins float onto their pull-downs until the latch, then drive.
    // The analog driver overlays the clock while the enable is low.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            FS_PIN_OE_N <= 5'h1f;
            WD_PIN_OE_N <= 1'b1;
            FS_PIN_O <= 5'h00;
            WD_PIN_O <= 1'b0;
        end else begin
            FS_PIN_OE_N <= {5{!strap_latched}};
            WD_PIN_OE_N <= !strap_latched;
            FS_PIN_O <= 5'h00;
            WD_PIN_O <= 1'b0;
        end
    end

    // power-down function
    // Before the latch the pin is the power-good strobe, so hold high.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            POWER_DOWN_N <= 1'b1;
        end else begin
            POWER_DOWN_N <= strap_latched ? pg_s : 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            IREF_MULT6 <= 1'b0;
        end else begin
            IREF_MULT6 <= STRAP.current_mode_strap;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [4:0] sw_code;
    logic sw_src;
    logic wd_sw_en;
    logic [15:0] clk_en;
    logic [7:0] wd_cnt;
    logic wd_timeout;
    logic wd_expire;
    logic wd_kick;
    logic glide_busy;
    logic [15:0] next_rdata;

    assign wd_kick = WR && ADDR == REG_WD_TIME;

    // Selection control; the watchdog reload goes straight into the live count.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            sw_code <= SW_CODE_RST;
            sw_src <= 1'b0;
            wd_sw_en <= 1'b1;
        end else if (WR && ADDR == REG_SEL_CTRL) begin
            sw_code <= WDATA[4:0];
            sw_src <= WDATA[SEL_SRC_BIT];
            wd_sw_en <= WDATA[SEL_WDEN_BIT];
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            clk_en <= CLK_EN_RST;
        end else if (WR && ADDR == REG_CLK_EN) begin
            clk_en <= WDATA;
        end
    end

    // Timeout flag: writing one clears, a fresh expiry wins.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            wd_timeout <= 1'b0;
        end else if (wd_expire) begin
            wd_timeout <= 1'b1;
        end else if (WR && ADDR == REG_STATUS && WDATA[ST_TIMEOUT_BIT]) begin
            wd_timeout <= 1'b0;
        end
    end

    // Read mux; unmapped words read zero.
    always_comb begin
        next_rdata = 16'h0000;
        unique case (ADDR)
            REG_SEL_CTRL: next_rdata = {9'h000, wd_sw_en, sw_src, sw_code};
            REG_CLK_EN: next_rdata = clk_en;
            REG_WD_TIME: next_rdata = {8'h00, wd_cnt};
            REG_STATUS: next_rdata = {FREQ_CODE, POWER_DOWN_N, strap_latched,
                glide_busy, wd_timeout, STRAP};
            REG_CPU_FREQ: next_rdata = CPU_FREQ;
            default: next_rdata = 16'h0000;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            RDATA <= 16'h0000;
        end else begin
            RDATA <= RD ? next_rdata : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Frequency selection
    // ------------------------------------------------------------
    logic [4:0] next_code;

    assign next_code = sw_src ? sw_code : STRAP.hw_freq_code;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            FREQ_CODE <= 5'h00;
            SPREAD_DOWN <= 1'b0;
        end else begin
            FREQ_CODE <= next_code;
            SPREAD_DOWN <= next_code == DOWN_CODE_A || next_code == DOWN_CODE_B;
        end
    end

    logic [$clog2(GLIDE_TICK_CYC)-1:0] tick_cnt;
    logic glide_tick;

    // Divider for the glide step enable.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            tick_cnt <= '0;
            glide_tick <= 1'b0;
        end else begin
            glide_tick <= tick_cnt == '0;
            if (tick_cnt == '0) begin
                tick_cnt <= ($clog2(GLIDE_TICK_CYC))'(GLIDE_TICK_CYC - 1);
            end else begin
                tick_cnt <= tick_cnt - 1'b1;
            end
        end
    end

    cfs_freq_glide u_glide (
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .tick(glide_tick),
        .target(CPU_FREQ_TAB[FREQ_CODE]),
        .cur(CPU_FREQ),
        .busy(glide_busy)
    );

    // output gating
    // Clocks run only once straps are in and power-down is released.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            CLK_GATE <= 16'h0000;
        end else begin
            CLK_GATE <= clk_en & {16{strap_latched && POWER_DOWN_N}};
        end
    end

    // ------------------------------------------------------------
    // Watchdog and reset pulse
    // ------------------------------------------------------------
    logic [31:0] unit_cnt;
    logic [31:0] rst_cnt;
    logic wd_run;

    assign wd_run = strap_latched && STRAP.watchdog_strap_enable && wd_sw_en;
    assign wd_expire = wd_run && wd_cnt == 8'h01 && unit_cnt == 32'h0;

    // Count down in 250 ms units; a write to the time word restarts.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            wd_cnt <= WD_TIME_RST;
            unit_cnt <= WD_UNIT_CYC - 1;
        end else if (wd_kick) begin
            wd_cnt <= WDATA[7:0];
            unit_cnt <= WD_UNIT_CYC - 1;
        end else if (wd_run && wd_cnt != 8'h00) begin
            if (unit_cnt == 32'h0) begin
                wd_cnt <= wd_cnt - 8'h01;
                unit_cnt <= WD_UNIT_CYC - 1;
            end else begin
                unit_cnt <= unit_cnt - 32'h1;
            end
        end
    end

    // reset pulse
    // Open drain: only ever pulls low, never drives high.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rst_cnt <= 32'h0;
            RST_PIN_OE_N <= 1'b1;
            RST_PIN_O <= 1'b0;
        end else if (wd_expire) begin
            rst_cnt <= RST_PULSE_CYC - 1;
            RST_PIN_OE_N <= 1'b0;
        end else if (rst_cnt != 32'h0) begin
            rst_cnt <= rst_cnt - 32'h1;
        end else begin
            RST_PIN_OE_N <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    sequence s_expire;
        wd_expire;
    endsequence

    sequence s_pulse_low;
        !RST_PIN_OE_N [*8];
    endsequence

    a_strap_capture_value: assert property (
        $rose(strap_latched) |-> STRAP.hw_freq_code == $past(fs_s))
        else $error("Strap code differs from sampled pins.");
    a_strap_hold_stable: assert property (
        strap_latched |=> $stable(STRAP))
        else $error("Latched straps changed.");
    a_pin_drive_turn: assert property (
        strap_latched |=> FS_PIN_OE_N == 5'h00 && !WD_PIN_OE_N)
        else $error("Strap pins not driving after latch.");
    a_pin_float_before: assert property (
        !strap_latched |-> FS_PIN_OE_N == 5'h1f)
        else $error("Strap pins driven before latch.");
    a_pd_held_high: assert property (
        !strap_latched |-> POWER_DOWN_N)
        else $error("Power-down asserted before latch.");
    a_code_source_sel: assert property (
        ##1 FREQ_CODE == ($past(sw_src) ? $past(sw_code) : $past(STRAP.hw_freq_code)))
        else $error("Frequency code from wrong source.");
    a_spread_code_map: assert property (
        SPREAD_DOWN == (FREQ_CODE == 5'h01 || FREQ_CODE == 5'h11))
        else $error("Spread mode does not match code.");
    a_reset_pulse_start: assert property (
        s_expire |=> s_pulse_low)
        else $error("Reset pulse missing or too short after expiry.");
    a_wd_strap_gate: assert property (
        strap_latched && !STRAP.watchdog_strap_enable && !wd_kick |=> $stable(wd_cnt))
        else $error("Watchdog counts with strap disabled.");
    a_iref_follow_strap: assert property (
        strap_latched ##1 strap_latched |-> IREF_MULT6 == STRAP.current_mode_strap)
        else $error("Current multiplier differs from strap.");
    a_gate_stop_pd: assert property (
        !POWER_DOWN_N |=> CLK_GATE == 16'h0000)
        else $error("Clocks running during power-down.");

endmodule : cfs_top

// ===== bench/cfs_board.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Board around the strap pins
// ------------------------------------------------------------
module cfs_board (
    input wire logic clk,
    input wire logic [4:0] fs_jumper,
    input wire logic wd_jumper,
    input wire logic [4:0] fs_oe_n,
    input wire logic wd_oe_n,
    input wire logic rst_o,
    input wire logic rst_oe_n,
    output logic [4:0] fs_pin,
    output logic wd_pin,
    output logic rst_line
);
    logic phase = 1'b0;

    // Clock overlay phase, so a driven pin never shows a still level.
    always @(posedge clk) begin
        phase <= ~phase;
    end

    // A floating pin shows its jumper; a driven pin carries a running clock.
    // pins toggle once driven
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            fs_pin[i] = fs_oe_n[i] ? fs_jumper[i] : (phase ^ fs_jumper[i]);
        end
        wd_pin = wd_oe_n ? wd_jumper : ~phase;
    end

    // Open-drain reset line with its pull-up resistor.
    // open drain reset
    assign rst_line = rst_oe_n ? 1'b1 : rst_o;
endmodule : cfs_board

// ===== bench/cfs_top_tb.sv
`timescale 1ns/1ps
module cfs_top_tb;
    import cfs_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic power_good = 1'b0;
    logic cur_strap = 1'b0;
    logic [4:0] fs_jumper = 5'h00;
    logic wd_jumper = 1'b1;
    logic [15:0] rdata, clk_gate, cpu_freq;
    logic [4:0] fs_pin, fs_oe_n, freq_code;
    logic wd_pin, wd_oe_n, rst_o, rst_oe_n, rst_line, power_down_n, spread_down, iref_mult6;
    cfs_strap_t strap;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    // ------------------------------------------------------------
    // Clock, design and board
    // ------------------------------------------------------------
    // Free-running 100 MHz system clock.
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    cfs_top #(.WD_UNIT_CYC(20), .RST_PULSE_CYC(16)) u_cfs_top (
        .CLK_SYS(clk_sys), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .POWER_GOOD_IN(power_good), .CURRENT_MODE_STRAP(cur_strap),
        .FS_PIN_I(fs_pin), .FS_PIN_O(), .FS_PIN_OE_N(fs_oe_n), .WD_PIN_I(wd_pin),
        .WD_PIN_O(), .WD_PIN_OE_N(wd_oe_n), .RST_PIN_O(rst_o), .RST_PIN_OE_N(rst_oe_n),
        .POWER_DOWN_N(power_down_n), .CLK_GATE(clk_gate), .FREQ_CODE(freq_code),
        .SPREAD_DOWN(spread_down), .CPU_FREQ(cpu_freq), .IREF_MULT6(iref_mult6),
        .STRAP(strap)
    );

    cfs_board u_cfs_board (
        .clk(clk_sys), .fs_jumper(fs_jumper), .wd_jumper(wd_jumper), .fs_oe_n(fs_oe_n),
        .wd_oe_n(wd_oe_n), .rst_o(rst_o), .rst_oe_n(rst_oe_n), .fs_pin(fs_pin),
        .wd_pin(wd_pin), .rst_line(rst_line)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic spread_exp(input logic [4:0] c);
        return (c == 5'h01) || (c == 5'h11);
    endfunction : spread_exp

    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so it is taken there.
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e,
                          input string nm);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata & m);
    endtask : rd_chk

    // Reset, then raise power good and check the capture and the pin turnaround.
    task automatic power_up(input logic [4:0] c, input logic m, input logic w);
        int n;
        resetn <= 1'b0;
        power_good <= 1'b0;
        fs_jumper <= c;
        wd_jumper <= w;
        cur_strap <= m;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("pins before latch", 16'h003f, {10'h000, wd_oe_n, fs_oe_n});
        chk("power down before latch", 16'h0001, {15'h0, power_down_n});
        chk("reset frequency", 16'h276a, cpu_freq);
        power_good <= 1'b1;
        n = 0;
        while (fs_oe_n !== 5'h00 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        repeat (2) @(posedge clk_sys);
        #1;
        chk("pins after latch", 16'h0000, {10'h000, wd_oe_n, fs_oe_n});
        chk("latched straps", {9'h000, c, m, w}, {9'h000, strap});
        chk("current multiplier", {15'h0, m}, {15'h0, iref_mult6});
        chk("hardware code", {11'h000, c}, {11'h000, freq_code});
        chk("spread mode", {15'h0, spread_exp(c)}, {15'h0, spread_down});
        chk("clock gates on", 16'hffff, clk_gate);
        repeat (20) @(posedge clk_sys);
        #1;
        chk("straps held", {9'h000, c, m, w}, {9'h000, strap});
    endtask : power_up

    // Restart the watchdog at two units and time the reset pulse on the board line.
    task automatic wd_check(input logic fire);
        int n;
        int m;
        n = 0;
        m = 0;
        while (rst_line === 1'b0 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        wr_reg(REG_WD_TIME, 16'h0002);
        n = 0;
        while (rst_line === 1'b1 && n < 80) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        while (rst_line === 1'b0 && m < 100) begin
            m++;
            @(posedge clk_sys);
            #1;
        end
        if (fire) begin
            chk("watchdog delay", 16'h0001, {15'h0, n >= 35 && n <= 50});
            chk("reset pulse width", 16'h0010, 16'(m));
            rd_chk(REG_WD_TIME, 16'hffff, 16'h0000, "count at expiry");
            rd_chk(REG_STATUS, 16'h0080, 16'h0080, "timeout set");
            wr_reg(REG_STATUS, 16'h0080);
            rd_chk(REG_STATUS, 16'h0080, 16'h0000, "timeout cleared");
        end else begin
            chk("no reset pulse", 16'h0050, 16'(n));
            rd_chk(REG_WD_TIME, 16'hffff, 16'h0002, "count held");
            rd_chk(REG_STATUS, 16'h0080, 16'h0000, "no timeout");
        end
    endtask : wd_check

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    // A hang is cut short well beyond the expected run of about 950 cycles.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            summarize();
        end
    end

    initial begin
        logic [31:0] r;
        logic [15:0] step, prev, d;
        int n;
        void'($urandom(32'h0184));
        r = $urandom;
        // The watchdog strap is held low here so the disabled path is always run.
        power_up(r[4:0], r[5], 1'b0);
        $display("test random strap capture done");
        // Every software code, with the watchdog enable kept set.
        for (int i = 0; i < 32; i++) begin
            wr_reg(REG_SEL_CTRL, 16'h0060 | 16'(i));
            @(posedge clk_sys);
            #1;
            chk("software code", 16'(i), {11'h000, freq_code});
            chk("spread per code", {15'h0, spread_exp(5'(i))}, {15'h0, spread_down});
        end
        wr_reg(REG_SEL_CTRL, 16'h0040);
        @(posedge clk_sys);
        #1;
        chk("back to straps", {11'h000, r[4:0]}, {11'h000, freq_code});
        rd_chk(REG_SEL_CTRL, 16'hffff, 16'h0040, "source control");
        rd_chk(REG_STATUS, 16'hfe7f, {r[4:0], 4'hc, r[4:0], r[5], 1'b0}, "status");
        rd_chk(4'hf, 16'hffff, 16'h0000, "unmapped read");
        wr_reg(REG_CLK_EN, r[31:16]);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("clock gates", r[31:16], clk_gate);
        $display("test software selection done");
        fs_jumper <= ~r[4:0];
        power_good <= 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        chk("power down level", 16'h0000, {15'h0, power_down_n});
        chk("clocks stopped", 16'h0000, clk_gate);
        power_good <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        chk("power down released", 16'h0001, {15'h0, power_down_n});
        chk("straps kept", {9'h000, r[4:0], r[5], 1'b0}, {9'h000, strap});
        wd_check(1'b0);
        $display("test power down and watchdog done");
        // Second reset in mid-run; code 1 lies six glide steps below the reset value.
        power_up(5'h01, 1'b1, 1'b1);
        step = 16'h0000;
        prev = cpu_freq;
        n = 0;
        while (cpu_freq !== 16'h272e && n < 1000) begin
            @(posedge clk_sys);
            #1;
            d = (cpu_freq > prev) ? cpu_freq - prev : prev - cpu_freq;
            if (d > step) begin
                step = d;
            end
            prev = cpu_freq;
            n++;
        end
        chk("glide step", 16'h000a, step);
        rd_chk(REG_CPU_FREQ, 16'hffff, 16'h272e, "glided frequency");
        wd_check(1'b1);
        $display("test glide and reset pulse done");
        summarize();
    end
endmodule : cfs_top_tb
